// ### hdl/spc_arm_window.sv
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"
// ****************************************************************
// arming window timer: counts cycles since the arming write
// ****************************************************************
module spc_arm_window #(
   parameter int SPM_WIN = `SPC_SPM_WIN,
   parameter int LPM_WIN = `SPC_LPM_WIN
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic arm,
   input  wire logic stop,
   output logic      spm_open,
   output logic      lpm_open,
   output logic      expire
);
   logic       active_q;   // window running
   logic [2:0] age_q;      // cycles since arming, 1 on first open cycle

   // age counter restarts on every arming write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         active_q <= 1'b0;
         age_q    <= 3'h0;
      end else if (arm) begin
         active_q <= 1'b1;
         age_q    <= 3'h1;
      end else if (stop || expire) begin
         active_q <= 1'b0;
      end else if (active_q) begin
         age_q <= age_q + 3'h1;
      end
   end

   assign spm_open = active_q && (age_q <= 3'(SPM_WIN));
   assign lpm_open = active_q && (age_q <= 3'(LPM_WIN));
   // last open cycle passes unused: window closes at this edge
   assign expire   = active_q && (age_q == 3'(SPM_WIN)) && !stop && !arm;
endmodule
`default_nettype wire

// ### hdl/spc_params.svh
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
// ****************************************************************
// register placement
// ****************************************************************
`define SPC_ADDR_DATA   8'h57
`define SPC_IO_OFFS     8'h20
`define SPC_ADDR_IO     (`SPC_ADDR_DATA - `SPC_IO_OFFS)
`define SPC_CSR_RESET   8'h00
// ****************************************************************
// control/status bit positions
// ****************************************************************
`define SPC_B_IRQEN     7
`define SPC_B_BUSY      6
`define SPC_B_SIGNATURE_ROW_READ     5
`define SPC_B_REEN      4
`define SPC_B_LOCK      3
`define SPC_B_PGWR      2
`define SPC_B_PGER      1
`define SPC_B_EN        0
// ****************************************************************
// flash geometry
// ****************************************************************
`define SPC_PC_W        16
`define SPC_PAGE_WORDS  128
`define SPC_RWW_PAGES   9'd480
`define SPC_NONCONCURRENT_SECTION_START  16'hf000
`define SPC_BOOT_512    16'hfe00
`define SPC_BOOT_1K     16'hfc00
`define SPC_BOOT_2K     16'hf800
`define SPC_BOOT_4K     16'hf000
// ****************************************************************
// arming windows, in cycles
// ****************************************************************
`define SPC_SPM_WIN     4
`define SPC_LPM_WIN     3
`endif

// ### hdl/spc_pkg.sv
package spc_pkg;
   // armed command kinds
   typedef enum logic [2:0] {
      SPC_CMD_NONE  = 3'b000,
      SPC_CMD_FILL  = 3'b001,
      SPC_CMD_ERASE = 3'b010,
      SPC_CMD_WRITE = 3'b011,
      SPC_CMD_LOCK  = 3'b100,
      SPC_CMD_REEN  = 3'b101,
      SPC_CMD_SIG   = 3'b110
   } spc_cmd_t;
   // sequencer states
   typedef enum logic [1:0] {
      SPC_ST_IDLE  = 2'b00,
      SPC_ST_ARMED = 2'b01,
      SPC_ST_BUSY  = 2'b10
   } spc_state_t;
endpackage

// ### hdl/spc_selfprog_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"
// Function
// - boot fuse picks boot size and start
// - concurrent section below 0xf000, 480 pages
// - 16-bit counter, 128-word pages
// - pointer high bits page, mid bits word
// - pointer bit 0 only byte-selects loads
// - register at 0x57, io 0x37, resets zero
// - ready irq while command enable clear
// - erase/write of concurrent section sets busy
// - busy clears on re-enable or fill
// - signature read via load, store ignored
// - re-enable store, never during running operation
// - re-enable write discards loaded buffer
// - lock-set store programs lock from low data
// - lock-set clears on completion or timeout
// - lock-set load returns lock or fuse
// - page write store writes buffer to page
// - page erase store erases selected page
// - enable alone fills buffer; held while busy
// - undefined command writes arm nothing; interrupt enable is still written
module spc_selfprog_ctrl (
   input  wire logic               mclk,
   input  wire logic               arst_n,
   // register access from the core
   input  wire logic [7:0]         io_addr,
   input  wire logic               io_space,
   input  wire logic               io_we,
   input  wire logic               io_re,
   input  wire logic [7:0]         io_wdata,
   output logic      [7:0]         io_rdata,
   // instruction strobes and operands
   input  wire logic               spm_exec,
   input  wire logic               lpm_exec,
   input  wire logic [16:0]        z_ptr,
   input  wire logic [7:0]         r0_data,
   input  wire logic [7:0]         r1_data,
   input  wire logic               global_irq_en,
   // fuses, lock bits, signature row
   input  wire logic [1:0]         boot_size_fuse,
   input  wire logic [7:0]         fuse_low,
   input  wire logic [7:0]         fuse_high,
   input  wire logic [7:0]         fuse_ext,
   input  wire logic [7:0]         lock_bits,
   output logic      [4:0]         sig_row_addr,
   input  wire logic [7:0]         sig_row_data,
   // flash array side
   input  wire logic               op_done,
   input  wire logic [15:0]        fetch_addr,
   output logic                    buf_we,
   output logic      [6:0]         buf_word,
   output logic      [15:0]        buf_data,
   output logic                    buf_discard,
   output logic                    page_erase_start,
   output logic                    page_write_start,
   output logic      [8:0]         page_sel,
   output logic                    lock_prog_start,
   output logic      [7:0]         lock_data,
   output logic                    rww_stall,
   output logic      [15:0]        boot_start,
   output logic                    lpm_valid,
   output logic      [7:0]         lpm_data,
   output logic                    ready_irq_req
);
   import spc_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // register decode for both address spaces
   function automatic logic reg_hit(input logic [7:0] a, input logic io);
      reg_hit = io ? (a == `SPC_ADDR_IO) : (a == `SPC_ADDR_DATA);
   endfunction

   // map a control write onto a command, anything else is none
   function automatic spc_cmd_t cmd_of(input logic [5:0] w);
      case (w)
         6'h21:   cmd_of = SPC_CMD_SIG;
         6'h01:   cmd_of = SPC_CMD_FILL;
         6'h03:   cmd_of = SPC_CMD_ERASE;
         6'h05:   cmd_of = SPC_CMD_WRITE;
         6'h09:   cmd_of = SPC_CMD_LOCK;
         6'h11:   cmd_of = SPC_CMD_REEN;
         default: cmd_of = SPC_CMD_NONE;
      endcase
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   spc_state_t state_q;         // sequencer state
   spc_cmd_t   cmd_q;           // armed or running command
   logic       irq_en_q;        // ready interrupt enable
   logic       busy_q;          // concurrent section busy
   logic       buf_loaded_q;    // temporary buffer holds data
   logic [7:0] csr;             // assembled register view
   logic       reg_wr;
   spc_cmd_t   wr_cmd;
   logic       arm;
   logic       spm_open;
   logic       lpm_open;
   logic       expire;
   logic       spm_hit;
   logic       lpm_hit;
   logic       read_cmd;
   logic       in_rww;          // pointer page lies in concurrent section
   logic       win_stop;        // a taken instruction other than a signature store closes the window

   assign reg_wr   = io_we && reg_hit(io_addr, io_space);
   assign wr_cmd   = cmd_of(io_wdata[5:0]);
   // a running operation locks out new commands
   assign arm      = reg_wr && (wr_cmd != SPC_CMD_NONE) && (state_q != SPC_ST_BUSY);
   // an arming write in the same cycle wins: it re-arms, so the strobe is not taken
   assign spm_hit  = (state_q == SPC_ST_ARMED) && spm_exec && spm_open && !arm;
   assign read_cmd = (cmd_q == SPC_CMD_SIG) || (cmd_q == SPC_CMD_LOCK);
   assign lpm_hit  = (state_q == SPC_ST_ARMED) && lpm_exec && lpm_open && read_cmd && !arm;
   // a signature store is a no-op, so the window keeps running for the load
   assign win_stop = lpm_hit || (spm_hit && cmd_q != SPC_CMD_SIG);
   assign in_rww   = z_ptr[16:8] < `SPC_RWW_PAGES;

   // ****************************************************************
   // arming window
   // ****************************************************************
   spc_arm_window #(
      .SPM_WIN (`SPC_SPM_WIN),
      .LPM_WIN (`SPC_LPM_WIN)
   ) u_win (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .arm      (arm),
      .stop     (win_stop),
      .spm_open (spm_open),
      .lpm_open (lpm_open),
      .expire   (expire)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   // command enable shows as any non-idle state
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= SPC_ST_IDLE;
         cmd_q   <= SPC_CMD_NONE;
      end else begin
         case (state_q)
            SPC_ST_IDLE: begin
               if (arm) begin
                  state_q <= SPC_ST_ARMED;
                  cmd_q   <= wr_cmd;
               end
            end
            SPC_ST_ARMED: begin
               if (arm) begin
                  // re-arm restarts the window with the new command
                  cmd_q <= wr_cmd;
               end else if (spm_hit) begin
                  case (cmd_q)
                     SPC_CMD_ERASE, SPC_CMD_WRITE, SPC_CMD_LOCK: begin
                        state_q <= SPC_ST_BUSY;
                     end
                     SPC_CMD_SIG: begin
                        state_q <= SPC_ST_ARMED;
                     end
                     default: begin
                        state_q <= SPC_ST_IDLE;
                        cmd_q   <= SPC_CMD_NONE;
                     end
                  endcase
               end else if (lpm_hit || expire) begin
                  state_q <= SPC_ST_IDLE;
                  cmd_q   <= SPC_CMD_NONE;
               end
            end
            SPC_ST_BUSY: begin
               // enable and the command bit stay up until the array is done
               if (op_done) begin
                  state_q <= SPC_ST_IDLE;
                  cmd_q   <= SPC_CMD_NONE;
               end
            end
            default: begin
               state_q <= SPC_ST_IDLE;
               cmd_q   <= SPC_CMD_NONE;
            end
         endcase
      end
   end

   // interrupt enable is writable whatever the command field holds
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_en_q <= 1'(`SPC_CSR_RESET >> `SPC_B_IRQEN);
      end else if (reg_wr) begin
         irq_en_q <= io_wdata[`SPC_B_IRQEN];
      end
   end

   // section busy flag, set on launch, cleared by re-enable or fill
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
      end else if (spm_hit && in_rww &&
                   (cmd_q == SPC_CMD_ERASE || cmd_q == SPC_CMD_WRITE)) begin
         busy_q <= 1'b1;
      end else if (spm_hit && (cmd_q == SPC_CMD_REEN || cmd_q == SPC_CMD_FILL)) begin
         busy_q <= 1'b0;
      end
   end

   // buffer occupancy, dropped by page write or a discard
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         buf_loaded_q <= 1'b0;
      end else if (spm_hit && cmd_q == SPC_CMD_FILL) begin
         buf_loaded_q <= 1'b1;
      end else if ((spm_hit && cmd_q == SPC_CMD_WRITE) ||
                   (arm && wr_cmd == SPC_CMD_REEN)) begin
         buf_loaded_q <= 1'b0;
      end
   end

   // ****************************************************************
   // array strobes and operands
   // ****************************************************************
   // one-cycle launch pulses with their operands captured alongside
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         buf_we           <= 1'b0;
         buf_word         <= 7'h00;
         buf_data         <= 16'h0000;
         buf_discard      <= 1'b0;
         page_erase_start <= 1'b0;
         page_write_start <= 1'b0;
         page_sel         <= 9'h000;
         lock_prog_start  <= 1'b0;
         lock_data        <= 8'h00;
      end else begin
         buf_we           <= spm_hit && cmd_q == SPC_CMD_FILL;
         buf_discard      <= arm && wr_cmd == SPC_CMD_REEN && buf_loaded_q;
         page_erase_start <= spm_hit && cmd_q == SPC_CMD_ERASE;
         page_write_start <= spm_hit && cmd_q == SPC_CMD_WRITE;
         lock_prog_start  <= spm_hit && cmd_q == SPC_CMD_LOCK;
         if (spm_hit) begin
            // z0 is ignored for every store; word bits pick the buffer slot
            buf_word  <= z_ptr[7:1];
            buf_data  <= {r1_data, r0_data};
            page_sel  <= z_ptr[16:8];
            lock_data <= r0_data;
         end
      end
   end

   // ****************************************************************
   // program-memory load return
   // ****************************************************************
   assign sig_row_addr = z_ptr[4:0];

   // z1:z0 pick the byte: 00 fuse low, 01 lock, 10 fuse ext, 11 fuse high
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lpm_valid <= 1'b0;
         lpm_data  <= 8'h00;
      end else begin
         lpm_valid <= lpm_hit;
         if (lpm_hit && cmd_q == SPC_CMD_SIG) begin
            lpm_data <= sig_row_data;
         end else if (lpm_hit) begin
            case (z_ptr[1:0])
               2'b00:   lpm_data <= fuse_low;
               2'b01:   lpm_data <= lock_bits;
               2'b10:   lpm_data <= fuse_ext;
               default: lpm_data <= fuse_high;
            endcase
         end
      end
   end

   // ****************************************************************
   // status, interrupt, section map
   // ****************************************************************
   always_comb begin
      csr                = 8'h00;
      csr[`SPC_B_IRQEN]  = irq_en_q;
      csr[`SPC_B_BUSY]   = busy_q;
      csr[`SPC_B_SIGNATURE_ROW_READ]  = cmd_q == SPC_CMD_SIG;
      csr[`SPC_B_REEN]   = cmd_q == SPC_CMD_REEN;
      csr[`SPC_B_LOCK]   = cmd_q == SPC_CMD_LOCK;
      csr[`SPC_B_PGWR]   = cmd_q == SPC_CMD_WRITE;
      csr[`SPC_B_PGER]   = cmd_q == SPC_CMD_ERASE;
      csr[`SPC_B_EN]     = state_q != SPC_ST_IDLE;
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         io_rdata <= `SPC_CSR_RESET;
      end else begin
         io_rdata <= (io_re && reg_hit(io_addr, io_space)) ? csr : 8'h00;
      end
   end

   // level request, held while enable is clear; core acks by masking
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ready_irq_req <= 1'b0;
      end else begin
         ready_irq_req <= irq_en_q && global_irq_en && state_q == SPC_ST_IDLE;
      end
   end

   // fetches into the concurrent section stall while it is busy
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rww_stall  <= 1'b0;
         boot_start <= `SPC_BOOT_512;
      end else begin
         rww_stall  <= busy_q && (fetch_addr < `SPC_NONCONCURRENT_SECTION_START);
         case (boot_size_fuse)
            2'b11:   boot_start <= `SPC_BOOT_512;
            2'b10:   boot_start <= `SPC_BOOT_1K;
            2'b01:   boot_start <= `SPC_BOOT_2K;
            default: boot_start <= `SPC_BOOT_4K;
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_irq_follow: assert property ((irq_en_q && global_irq_en && state_q == SPC_ST_IDLE)
      |=> ready_irq_req) else $error("ready irq missing");
   a_busy_set: assert property ((spm_hit && in_rww && cmd_q == SPC_CMD_ERASE)
      |=> busy_q && page_erase_start) else $error("busy not set");
   a_busy_clr: assert property ((spm_hit && cmd_q == SPC_CMD_FILL)
      |=> !busy_q && buf_we) else $error("fill left busy");
   a_sig_noop: assert property ((spm_hit && cmd_q == SPC_CMD_SIG) |=> !page_erase_start
      && !page_write_start && !buf_we && !lock_prog_start) else $error("sig store acted");
   a_busy_lock: assert property ((state_q == SPC_ST_BUSY && !op_done)
      |=> state_q == SPC_ST_BUSY && csr[`SPC_B_EN]) else $error("enable dropped");
   a_bad_write: assert property ((state_q == SPC_ST_IDLE && reg_wr && wr_cmd == SPC_CMD_NONE)
      |=> state_q == SPC_ST_IDLE) else $error("bad write armed");
   a_discard: assert property ((arm && wr_cmd == SPC_CMD_REEN && buf_loaded_q)
      |=> buf_discard && !buf_loaded_q) else $error("no discard");
   a_lock_data: assert property ((spm_hit && cmd_q == SPC_CMD_LOCK)
      |=> lock_prog_start && lock_data == $past(r0_data)) else $error("lock data");
   a_page_sel: assert property ((spm_hit && cmd_q == SPC_CMD_WRITE)
      |=> page_write_start && page_sel == $past(z_ptr[16:8])) else $error("page sel");
   a_win_close: assert property ((arm && state_q == SPC_ST_IDLE) ##1
      (!spm_exec && !lpm_exec && !reg_wr)[*4] |=> state_q == SPC_ST_IDLE)
      else $error("window stuck");

   c_erase: cover property (spm_hit && cmd_q == SPC_CMD_ERASE ##[1:60] op_done);
   c_fill: cover property (spm_hit && cmd_q == SPC_CMD_FILL);
   c_lock_read: cover property (lpm_hit && cmd_q == SPC_CMD_LOCK);
   c_timeout: cover property (expire);
endmodule
`default_nettype wire

// ### verification/spc_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// flash array model: ends each launched operation after a delay
// ****************************************************************
module spc_flash_model (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic start,
   output logic      op_done
);
   int left; // cycles until the running operation ends
   // one operation at a time; a random delay covers prompt and slow arrays
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         left    <= 0;
         op_done <= 1'b0;
      end else begin
         op_done <= (left == 1);
         if (start) begin
            left <= 20 + ($urandom % 30);
         end else if (left != 0) begin
            left <= left - 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/tb_flash_self_program_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "spc_params.svh"
// ****************************************************************
// self-programming control bench: core side driven, array modelled
// ****************************************************************
module tb_flash_self_program_control;
   import spc_pkg::*;
   logic        mclk, arst_n, io_space, io_we, io_re, spm_exec, lpm_exec, global_irq_en, op_done;
   logic [7:0]  io_addr, io_wdata, io_rdata, r0_data, r1_data, fuse_low, fuse_high, fuse_ext;
   logic [7:0]  lock_bits, sig_row_data, lock_data, lpm_data, c;
   logic [16:0] z_ptr, zz;
   logic [1:0]  boot_size_fuse;
   logic [4:0]  sig_row_addr;
   logic [15:0] fetch_addr, buf_data, boot_start, dd;
   logic [6:0]  buf_word;
   logic [8:0]  page_sel, pg;
   logic        buf_we, buf_discard, page_erase_start, page_write_start, lock_prog_start;
   logic        rww_stall, lpm_valid, ready_irq_req, hit, d0, d1;
   logic        re_d = 1'b0;                   // a read answer is due this edge
   logic [31:0] got, notes[$];                 // expected results, oldest first
   logic [15:0] bs [4] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfe00};
   logic [7:0]  fb [4];                        // fuse/lock byte per pointer low bits
   logic [7:0]  bad [7] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h1f, 8'h07, 8'h06};
   logic [7:0]  arm [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
   int          n_fail = 0;
   int          comparisons = 0;
   int          ticks = 0;
   // signature row stand-in: byte follows the address, so addressing shows
   assign sig_row_data = {3'h2, sig_row_addr};
   spc_selfprog_ctrl dut (.mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_space(io_space),
      .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .spm_exec(spm_exec), .lpm_exec(lpm_exec), .z_ptr(z_ptr), .r0_data(r0_data),
      .r1_data(r1_data), .global_irq_en(global_irq_en), .boot_size_fuse(boot_size_fuse),
      .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext), .lock_bits(lock_bits),
      .sig_row_addr(sig_row_addr), .sig_row_data(sig_row_data), .op_done(op_done),
      .fetch_addr(fetch_addr), .buf_we(buf_we), .buf_word(buf_word), .buf_data(buf_data),
      .buf_discard(buf_discard), .page_erase_start(page_erase_start),
      .page_write_start(page_write_start), .page_sel(page_sel),
      .lock_prog_start(lock_prog_start), .lock_data(lock_data), .rww_stall(rww_stall),
      .boot_start(boot_start), .lpm_valid(lpm_valid), .lpm_data(lpm_data),
      .ready_irq_req(ready_irq_req));
   spc_flash_model array (.mclk(mclk), .arst_n(arst_n),
      .start(page_erase_start | page_write_start | lock_prog_start), .op_done(op_done));
   // free-running clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // one-cycle register write at the current io_addr/io_space
   task automatic wr(input logic [7:0] v);
      io_wdata <= v;
      io_we    <= 1'b1;
      @(posedge mclk);
      io_we    <= 1'b0;
   endtask
   // read strobe; the extra edge keeps two reads from sharing a time step
   task automatic rd(input logic [7:0] a, input logic s, input logic [7:0] e);
      io_addr  <= a;
      io_space <= s;
      io_re    <= 1'b1;
      notes.push_back({8'h2, 16'h0, e});
      @(posedge mclk);
      io_re    <= 1'b0;
      io_addr  <= `SPC_ADDR_DATA;
      io_space <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rdc(input logic [7:0] e);
      rd(`SPC_ADDR_DATA, 1'b0, e);
   endtask
   // store (l=0) or load (l=1) instruction strobe
   task automatic ex(input logic l);
      if (l) lpm_exec <= 1'b1;
      else spm_exec <= 1'b1;
      @(posedge mclk);
      if (l) lpm_exec <= 1'b0;
      else spm_exec <= 1'b0;
   endtask
   task automatic wait_done;
      int i;
      for (i = 0; i < 200 && op_done !== 1'b1; i++)
         @(posedge mclk);
      check("op_done wait", 32'h1, {31'h0, i < 200});
      cyc(2);
   endtask
   // result watcher: every result takes the oldest note off the queue
   always @(posedge mclk) begin
      hit = 1'b1;
      if (re_d) got = {8'h2, 16'h0, io_rdata};
      else if (lpm_valid === 1'b1) got = {8'h1, 16'h0, lpm_data};
      else if (page_erase_start === 1'b1) got = {8'h3, 15'h0, page_sel};
      else if (page_write_start === 1'b1) got = {8'h4, 15'h0, page_sel};
      else if (lock_prog_start === 1'b1) got = {8'h5, 16'h0, lock_data};
      else if (buf_we === 1'b1) got = {8'h6, 1'b0, buf_word, buf_data};
      else hit = 1'b0;
      re_d <= io_re;
      if (hit && notes.size() == 0) check("unexpected result", 32'h0, got);
      else if (hit) check("result", notes.pop_front(), got);
   end
   // hang guard
   always @(posedge mclk) begin
      ticks++;
      if (ticks == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(65));
      {arst_n, io_space, io_we, io_re, spm_exec, lpm_exec} = 6'h0;
      global_irq_en = 1'b0;
      {io_wdata, z_ptr, r0_data, r1_data, boot_size_fuse} = '0;
      io_addr = `SPC_ADDR_DATA;
      fetch_addr = 16'h1234;
      {fuse_low, lock_bits, fuse_ext, fuse_high} = $urandom;
      fb = '{fuse_low, lock_bits, fuse_ext, fuse_high};
      cyc(4);
      arst_n <= 1'b1;
      @(posedge mclk);
      for (int f = 0; f < 4; f++) begin
         boot_size_fuse <= f[1:0];
         cyc(3);
         check("boot_start", {16'h0, bs[f]}, {16'h0, boot_start});
      end
      rdc(`SPC_CSR_RESET);
      rd(`SPC_ADDR_IO, 1'b1, 8'h00);
      rd(8'h58, 1'b0, 8'h00);
      // erase then write to the concurrent section, both with busy tracking
      for (int k = 0; k < 2; k++) begin
         c = k ? 8'h05 : 8'h03;
         pg = 9'($urandom % 480);
         z_ptr <= {pg, 8'h00};
         notes.push_back({k ? 8'h4 : 8'h3, 15'h0, pg});
         wr(c);
         ex(1'b0);
         cyc(2);
         check("rww_stall", 32'h1, {31'h0, rww_stall});
         rdc(c | 8'h40);
         wr(8'h11);
         rdc(c | 8'h40);
         fetch_addr <= 16'hf000;
         cyc(2);
         check("rww_stall", 32'h0, {31'h0, rww_stall});
         fetch_addr <= 16'h1234;
         wait_done();
         rdc(8'h40);
         if (k == 0) begin
            wr(8'h11);
            ex(1'b0);
            cyc(1);
            rdc(8'h00);
         end
      end
      for (int k = 0; k < 3; k++) begin
         zz = 17'($urandom);
         dd = 16'($urandom);
         z_ptr <= zz;
         {r1_data, r0_data} <= dd;
         notes.push_back({8'h6, 1'b0, zz[7:1], dd});
         wr(8'h01);
         cyc(k);
         ex(1'b0);
         cyc(1);
      end
      rdc(8'h00);
      wr(8'h11);
      @(negedge mclk) d0 = buf_discard;
      @(negedge mclk) d1 = buf_discard;
      @(posedge mclk);
      check("buf_discard", 32'h1, {31'h0, d0 | d1});
      ex(1'b0);
      r0_data <= 8'($urandom);
      r1_data <= 8'($urandom);
      z_ptr <= 17'($urandom);
      cyc(1);
      notes.push_back({8'h5, 16'h0, r0_data});
      wr(8'h09);
      ex(1'b0);
      cyc(2);
      wait_done();
      rdc(8'h00);
      foreach (arm[i]) begin
         wr(arm[i]);
         cyc(4);
         ex(1'b0);
         rdc(8'h00);
      end
      for (int k = 0; k < 4; k++) begin
         z_ptr <= 17'(k);
         notes.push_back({8'h1, 16'h0, fb[k]});
         wr(8'h09);
         cyc(k % 3);
         ex(1'b1);
         cyc(1);
      end
      zz = 17'($urandom % 32);
      z_ptr <= zz;
      notes.push_back({8'h1, 16'h0, 3'h2, zz[4:0]});
      wr(8'h21);
      ex(1'b0);
      ex(1'b1);
      cyc(1);
      foreach (bad[i]) begin
         wr(bad[i]);
         ex(1'b0);
         rdc(8'h00);
      end
      global_irq_en <= 1'b1;
      // interrupt enable written through the i/o-space alias
      io_addr  <= `SPC_ADDR_IO;
      io_space <= 1'b1;
      wr(8'h80);
      cyc(3);
      check("ready_irq_req", 32'h1, {31'h0, ready_irq_req});
      rdc(8'h80);
      rd(`SPC_ADDR_IO, 1'b1, 8'h80);
      global_irq_en <= 1'b0;
      cyc(3);
      check("ready_irq_req", 32'h0, {31'h0, ready_irq_req});
      cyc(2);
      check("notes left", 32'h0, notes.size());
      print_verdict();
   end
endmodule
`default_nettype wire
